// ---- bench/accel_gyro_lowpower_filter_config_tb_top.sv ----
/* Self-checking bench for the filter configuration block.
   The host model works the register port; loose inputs come from here. */
`timescale 1ns/1ps
module accel_gyro_lowpower_filter_config_tb_top;
	typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_t;
	// Rows: address, byte written, byte read back.
	row_t rows[4] = '{'{8'h1d, 8'hff, 8'h3f}, '{8'h1e, 8'hff, 8'hf0}, '{8'h1f, 8'ha5, 8'ha5}, '{8'h5a, 8'h3c, 8'h00}};
	logic [2:0] wen[5] = '{3'h7, 3'h2, 3'h0, 3'h5, 3'h7};
	logic       warm[5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
	logic       sys_clk = 1'b0, rstn = 1'b0, accel_lp_mode = 1'b0, accel_sample_valid = 1'b0;
	logic       reg_wr, reg_rd, accel_out_valid, accel_power_en, odr_strobe, gyro_lp_mode, motion_wake_armed;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, gyro_avg_count, motion_wake_level, v;
	logic [7:0] rate_divider = 8'h00;
	logic [2:0] gyro_lowpass_sel = 3'h5, motion_wake_irq_en = 3'h0, gyro_filter_code;
	logic [3:0] accel_bw_code;
	logic signed [15:0] accel_sample = 16'h0000, accel_out;
	int         failures = 0, comparisons = 0, cycles = 0, t;
	always #20 sys_clk = ~sys_clk;
	accel_gyro_lowpower_filter_config #(.FILTERED_PERIOD(20), .BYPASS_PERIOD(5)) dut_u (.sys_clk, .rstn,
		.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .accel_lp_mode, .rate_divider, .gyro_lowpass_sel,
		.motion_wake_irq_en, .accel_sample, .accel_sample_valid, .accel_out, .accel_out_valid, .accel_power_en,
		.accel_bw_code, .odr_strobe, .gyro_lp_mode, .gyro_filter_code, .gyro_avg_count, .motion_wake_level,
		.motion_wake_armed);
	host_model host_u (.sys_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
	// ====================
	// Checking and closing
	// ====================
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		comparisons++;
		if (g !== e) begin
			failures++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic test_done();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic wait_odr(output int k);
		k = 0;
		do begin
			@(posedge sys_clk);
			k++;
		end while (!odr_strobe && k < 400);
	endtask
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			test_done();
		end
	end
	// ====================
	// Sequence
	// ====================
	initial begin
		repeat (8) @(posedge sys_clk);
		chk("gyro_avg_count", 16'h0001, gyro_avg_count);
		chk("gyro_lp_mode", 16'h0000, gyro_lp_mode);
		rstn <= 1'b1;
		for (int a = 'h1d; a <= 'h1f; a++) begin
			host_u.rd(8'(a), v);
			chk("reset value", 16'h0000, v);
		end
		foreach (rows[i]) begin
			host_u.wr(rows[i].a, rows[i].d);
			host_u.rd(rows[i].a, v);
			chk("readback", {8'h00, rows[i].e}, v);
		end
		chk("motion_wake_level", 16'h00a5, motion_wake_level);
		for (int c = 0; c < 16; c++) begin
			host_u.wr(8'h1d, 8'(c));
			@(posedge sys_clk);
			#1 chk("accel_bw_code", c[3] ? 16'h0008 : 16'(c[2:0]), accel_bw_code);
		end
		for (int c = 0; c < 9; c++) begin
			host_u.wr(8'h1e, (c < 8) ? {1'b1, 3'(c), 4'h0} : 8'h70);
			gyro_lowpass_sel <= 3'(c + 3);
			@(posedge sys_clk);
			#1 chk("gyro_filter_code", (c < 8) ? 16'(c) : 16'h0003, gyro_filter_code);
			chk("gyro_avg_count", (c < 8) ? 16'h0001 << c : 16'h0001, gyro_avg_count);
		end
		foreach (wen[i]) begin
			@(posedge sys_clk);
			motion_wake_irq_en <= wen[i];
			@(posedge sys_clk);
			#1 chk("motion_wake_armed", 16'(warm[i]), motion_wake_armed);
		end
		for (int b = 0; b < 4; b++) begin
			host_u.wr(8'h1d, {4'h0, b[1], 3'h0});
			rate_divider <= 8'(2 * b[0]);
			accel_sample <= 16'(100 + b);
			accel_sample_valid <= 1'b1;
			repeat (3) wait_odr(t);
			chk("odr period", 16'((b[1] ? 5 : 20) * (1 + 2 * b[0])), 16'(t));
			chk("accel_out", 16'(100 + b), accel_out);
			chk("accel_out_valid", 16'h0001, accel_out_valid);
		end
		accel_sample_valid <= 1'b0;
		rate_divider <= 8'h03;
		accel_lp_mode <= 1'b1;
		for (int s = 0; s < 4; s++) begin
			host_u.wr(8'h1d, {2'b00, 2'(s), 4'h0});
			repeat (2) wait_odr(t);
			chk("accel_power_en", 16'h0001, accel_power_en);
			for (int n = 0; n < (4 << s); n++) begin
				accel_sample <= 16'(-16 * (s + 1) + 2 * (n % 2));
				accel_sample_valid <= 1'b1;
				@(posedge sys_clk);
			end
			accel_sample_valid <= 1'b0;
			for (t = 0; t < 4 && !accel_out_valid; t++) begin
				@(posedge sys_clk);
			end
			chk("accel_out", 16'(-16 * (s + 1) + 1), accel_out);
			chk("accel_power_en", 16'h0000, accel_power_en);
		end
		rstn <= 1'b0;
		repeat (2) @(posedge sys_clk);
		chk("gyro_avg_count", 16'h0001, gyro_avg_count);
		rstn <= 1'b1;
		host_u.rd(8'h1e, v);
		chk("reset value", 16'h0000, v);
		test_done();
	end
endmodule

// ---- bench/host_model.sv ----
/* Host side of the register port: single-byte writes and reads.
   Assumes strobes are taken on the rising sys_clk edge. */
`timescale 1ns/1ps
module host_model (
	// Clock
	input  wire logic       sys_clk,
	// Register port
	output logic [7:0]      reg_addr,
	output logic [7:0]      reg_wdata,
	output logic            reg_wr,
	output logic            reg_rd,
	input  wire logic [7:0] reg_rdata
);
	// Idle address and data are inverted so a decode without its strobe shows.
	initial {reg_addr, reg_wdata, reg_wr, reg_rd} = {16'hffff, 2'b00};
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		{reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
		@(posedge sys_clk);
		{reg_addr, reg_wdata, reg_wr} <= {~a, ~d, 1'b0};
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		{reg_addr, reg_rd} <= {a, 1'b1};
		@(posedge sys_clk);
		{reg_addr, reg_rd} <= {~a, 1'b0};
		@(posedge sys_clk);
		d = reg_rdata;
	endtask
endmodule

// ---- bench/motion_filter_properties.sv ----
/* Assertion checker for the filter configuration block, bound to its top.
   Assumes one clock domain and an asynchronous active-low reset. */
`timescale 1ns/1ps
module motion_filter_properties
	import motion_filter_pkg::*;
#(
	parameter int FILTERED_PERIOD = FILTERED_CYCLES,
	parameter int BYPASS_PERIOD   = BYPASS_CYCLES
) (
	// Watched ports
	input wire logic       sys_clk, rstn, reg_wr, accel_lp_mode, accel_out_valid, accel_power_en,
	input wire logic       odr_strobe, gyro_lp_mode, motion_wake_armed,
	input wire logic [7:0] reg_addr, reg_wdata, rate_divider, gyro_avg_count, motion_wake_level,
	input wire logic [2:0] gyro_lowpass_sel, motion_wake_irq_en, gyro_filter_code,
	input wire logic [3:0] accel_bw_code
);
	// A period is judged only when divider and bypass held still through it.
	// A filter register write counts as a move, since the timer sees it a cycle before the bandwidth code.
	int   gap;
	logic moved;
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			gap   <= 0;
			moved <= 1'b1;
		end else begin
			gap   <= odr_strobe ? 1 : gap + 1;
			moved <= !odr_strobe && (moved || $changed(rate_divider) || $changed(accel_bw_code[3])
				|| (reg_wr && reg_addr == 8'h1d));
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	// ====================
	// Properties
	// ====================
	a_bw_code: assert property (reg_wr && reg_addr == 8'h1d |-> ##2
		accel_bw_code == ($past(reg_wdata[3], 2) ? 4'h8 : {1'b0, $past(reg_wdata[2:0], 2)})) else $error("bw code wrong");
	a_gyro_cycle: assert property (reg_wr && reg_addr == 8'h1e |-> ##2
		gyro_lp_mode == $past(reg_wdata[7], 2)) else $error("gyro mode wrong");
	a_gyro_avg: assert property (reg_wr && reg_addr == 8'h1e && reg_wdata[7] |-> ##2
		gyro_filter_code == $past(reg_wdata[6:4], 2) && gyro_avg_count == 8'h01 << $past(reg_wdata[6:4], 2))
		else $error("gyro averaging wrong");
	a_gyro_normal: assert property ($past(rstn) && !gyro_lp_mode |->
		gyro_filter_code == $past(gyro_lowpass_sel) && gyro_avg_count == 8'h01) else $error("gyro code wrong");
	a_odr_period: assert property (odr_strobe && !moved |->
		gap == (accel_bw_code[3] ? BYPASS_PERIOD : FILTERED_PERIOD) * (1 + $past(rate_divider)))
		else $error("odr period wrong");
	a_wake_arm: assert property ($past(rstn) |-> motion_wake_armed ==
		($past(motion_wake_irq_en) == 3'b111 || ($past(motion_wake_irq_en) != 3'b000 && $past(motion_wake_armed))))
		else $error("wake arming wrong");
	a_wake_level: assert property (reg_wr && reg_addr == 8'h1f |-> ##2
		motion_wake_level == $past(reg_wdata, 2)) else $error("wake level wrong");
	a_window_open: assert property (accel_lp_mode && $past(accel_lp_mode) && odr_strobe |-> accel_power_en)
		else $error("window not powered");
	a_window_close: assert property (accel_lp_mode && $past(accel_lp_mode, 2) && $fell(accel_power_en)
		|-> ##[0:1] accel_out_valid) else $error("no result after window");
endmodule
bind accel_gyro_lowpower_filter_config motion_filter_properties #(.FILTERED_PERIOD(FILTERED_PERIOD),
	.BYPASS_PERIOD(BYPASS_PERIOD)) chk_u (.sys_clk, .rstn, .reg_wr, .accel_lp_mode, .accel_out_valid,
	.accel_power_en, .odr_strobe, .gyro_lp_mode, .motion_wake_armed, .reg_addr, .reg_wdata, .rate_divider,
	.gyro_avg_count, .motion_wake_level, .gyro_lowpass_sel, .motion_wake_irq_en, .gyro_filter_code, .accel_bw_code);

// ---- hdl/accel_gyro_lowpower_filter_config.sv ----
/*
 * Filter, decimation and low-power cycling configuration for a 6-axis sensor.
 * Holds three host registers, generates the divided output-rate strobe,
 * duty-cycles and averages the accelerometer, and steers the gyro filter.
 * Assumes all inputs are synchronous to sys_clk and that register accesses
 * arrive as single-cycle strobes from the serial host interface.
 */
// What this block does
// RL1 - Low-power accel averages 4, 8, 16, 32 samples.
// RL2 - Bypass skips accel low-pass, 4 kHz rate.
// RL3 - Filter code picks accel bandwidth at 1 kHz.
// RL4 - Output rate divided by one plus divider.
// RL5 - Low-power accel powered only while averaging.
// RL6 - Gyro cycle bit enables low-power gyro; resets 0.
// RL7 - Host sets gyro cycle before low-power gyro.
// RL8 - Gyro averages two to the code; resets zero.
// RL9 - Low-power gyro ignores normal gyro low-pass code.
// RL10 - Eight-bit wake threshold held for motion logic.
// RL11 - Wake interrupt enabled all ones, disabled zeros.
// RL12 - Host avoids averaging longer than sample period.
// RL13 - Reserved config bits read zero, ignore writes.
`timescale 1ns/1ps

module accel_gyro_lowpower_filter_config
	import motion_filter_pkg::*;
#(
	parameter int FILTERED_PERIOD = FILTERED_CYCLES,
	parameter int BYPASS_PERIOD   = BYPASS_CYCLES
) (
	// Clock and reset
	input  wire logic                           sys_clk,
	input  wire logic                           rstn,
	// Register port
	input  wire logic [7:0]                     reg_addr,
	input  wire logic [7:0]                     reg_wdata,
	input  wire logic                           reg_wr,
	input  wire logic                           reg_rd,
	output logic [7:0]                          reg_rdata,
	// Loose configuration from neighbouring registers
	input  wire logic                           accel_lp_mode,
	input  wire logic [7:0]                     rate_divider,
	input  wire logic [2:0]                     gyro_lowpass_sel,
	input  wire logic [2:0]                     motion_wake_irq_en,
	// Accelerometer sample stream
	input  wire logic signed [SAMPLE_WIDTH-1:0] accel_sample,
	input  wire logic                           accel_sample_valid,
	// Accelerometer results and control
	output logic signed [SAMPLE_WIDTH-1:0]      accel_out,
	output logic                                accel_out_valid,
	output logic                                accel_power_en,
	output logic [3:0]                          accel_bw_code,
	output logic                                odr_strobe,
	// Gyroscope control
	output logic                                gyro_lp_mode,
	output logic [2:0]                          gyro_filter_code,
	output logic [7:0]                          gyro_avg_count,
	// Wake-on-motion
	output logic [7:0]                          motion_wake_level,
	output logic                                motion_wake_armed
);

	// ==========================================================================
	// State
	// ==========================================================================
	typedef struct packed {
		logic [5:0]                      accel_cfg;
		logic [3:0]                      lp_cfg;
		logic [7:0]                      wake_level;
		logic [14:0]                     tick_cnt;
		logic [7:0]                      div_cnt;
		logic [5:0]                      avg_cnt;
		logic                            averaging;
		logic                            finishing;
		logic signed [SAMPLE_WIDTH-1:0]  last_sample;
		logic [7:0]                      rdata;
		logic signed [SAMPLE_WIDTH-1:0]  out;
		logic                            out_valid;
		logic                            power_en;
		logic [3:0]                      bw_code;
		logic                            odr;
		logic                            gyro_lp;
		logic [2:0]                      gyro_code;
		logic [7:0]                      gyro_count;
		logic                            wake_armed;
	} top_state_t;

	top_state_t state;
	top_state_t next_state;

	logic signed [SUM_WIDTH-1:0] acc_sum;
	logic                        acc_clear;
	logic                        acc_add;

	function automatic logic [2:0] avg_shift(input logic [1:0] sel);
		avg_shift = {1'b0, sel} + ACCEL_AVG_BASE_SHIFT;
	endfunction

	// ==========================================================================
	// Next-state logic
	// ==========================================================================
	logic [1:0]  avg_sel;
	logic        bypass;
	logic [14:0] period_last;
	logic        base_tick;
	logic        odr_tick;

	always_comb begin
		avg_sel     = state.accel_cfg[ACCEL_LP_AVG_SEL_LSB +: 2];
		bypass      = state.accel_cfg[ACCEL_FILTER_BYPASS_BIT];
		period_last = bypass ? 15'(BYPASS_PERIOD - 1) : 15'(FILTERED_PERIOD - 1); // [RL2] [RL3]
		base_tick   = (state.tick_cnt >= period_last);
		odr_tick    = base_tick && (state.div_cnt >= rate_divider); // [RL4]
		acc_clear   = 1'b0;
		acc_add     = 1'b0;

		next_state           = state;
		next_state.odr       = 1'b0;
		next_state.out_valid = 1'b0;
		next_state.finishing = 1'b0;

		// Register writes keep only the defined fields. [RL13]
		if (reg_wr) begin
			case (reg_addr)
				ADDR_ACCEL_FILTER_CFG2:     next_state.accel_cfg = reg_wdata[5:0];
				ADDR_LOW_POWER_CFG:         next_state.lp_cfg = reg_wdata[7:4]; // [RL6] [RL8]
				ADDR_MOTION_WAKE_THRESHOLD: next_state.wake_level = reg_wdata; // [RL10]
				default:                    next_state.lp_cfg = state.lp_cfg;
			endcase
		end
		if (reg_rd) begin
			case (reg_addr)
				ADDR_ACCEL_FILTER_CFG2:     next_state.rdata = {2'b00, state.accel_cfg}; // [RL13]
				ADDR_LOW_POWER_CFG:         next_state.rdata = {state.lp_cfg, 4'h0}; // [RL13]
				ADDR_MOTION_WAKE_THRESHOLD: next_state.rdata = state.wake_level;
				default:                    next_state.rdata = 8'h00;
			endcase
		end

		// Base-rate timer and output-rate divider.
		next_state.tick_cnt = base_tick ? 15'd0 : state.tick_cnt + 15'd1;
		if (base_tick) begin
			next_state.div_cnt = odr_tick ? 8'd0 : state.div_cnt + 8'd1; // [RL4]
		end
		next_state.odr = odr_tick;

		if (accel_sample_valid) begin
			next_state.last_sample = accel_sample;
		end

		if (accel_lp_mode) begin
			// A new output period restarts the window even if the last one
			// never completed, so an overlong setting degrades, not hangs.
			if (odr_tick) begin
				next_state.averaging = 1'b1;
				next_state.power_en  = 1'b1; // [RL5]
				next_state.avg_cnt   = 6'd0;
				acc_clear            = 1'b1;
			end else if (state.averaging && accel_sample_valid) begin
				acc_add           = 1'b1;
				next_state.avg_cnt = state.avg_cnt + 6'd1;
				if (state.avg_cnt + 6'd1 == (6'd1 << avg_shift(avg_sel))) begin // [RL1]
					next_state.averaging = 1'b0;
					next_state.power_en  = 1'b0; // [RL5]
					next_state.finishing = 1'b1;
				end
			end else if (!state.averaging) begin
				// Between windows the sensor stays off, even right after entering this mode.
				next_state.power_en = 1'b0; // [RL5]
			end
			if (state.finishing) begin
				next_state.out       = SAMPLE_WIDTH'(acc_sum >>> avg_shift(avg_sel)); // [RL1]
				next_state.out_valid = 1'b1;
			end
		end else begin
			next_state.averaging = 1'b0;
			next_state.power_en  = 1'b1;
			if (odr_tick) begin
				next_state.out       = state.last_sample;
				next_state.out_valid = 1'b1; // [RL4]
			end
		end

		// Effective filter selections.
		next_state.bw_code    = bypass ? ACCEL_BW_BYPASSED
			: {1'b0, state.accel_cfg[ACCEL_LOWPASS_SEL_LSB +: 3]}; // [RL2] [RL3]
		next_state.gyro_lp    = state.lp_cfg[3]; // [RL6]
		next_state.gyro_code  = state.lp_cfg[3] ? state.lp_cfg[2:0] : gyro_lowpass_sel; // [RL9]
		next_state.gyro_count = state.lp_cfg[3] ? (8'd1 << state.lp_cfg[2:0]) : 8'd1; // [RL8]

		// Only the two documented enable codes change the arming. [RL11]
		if (motion_wake_irq_en == WAKE_EN_ALL_ONES) begin
			next_state.wake_armed = 1'b1;
		end else if (motion_wake_irq_en == 3'b000) begin
			next_state.wake_armed = 1'b0;
		end
	end

	// ==========================================================================
	// Registers
	// ==========================================================================
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state            <= '0;
			state.accel_cfg  <= ACCEL_CFG_RESET;
			state.lp_cfg     <= LP_CFG_RESET; // [RL6] [RL8]
			state.wake_level <= WAKE_LEVEL_RESET;
			state.gyro_count <= 8'd1;
		end else begin
			state <= next_state;
		end
	end

	avg_accumulator #(
		.SAMPLE_W (SAMPLE_WIDTH),
		.SUM_W    (SUM_WIDTH)
	) u_accel_avg (
		.sys_clk (sys_clk),
		.rstn    (rstn),
		.clear   (acc_clear),
		.add_en  (acc_add),
		.sample  (accel_sample),
		.sum     (acc_sum)
	);

	// ==========================================================================
	// Outputs
	// ==========================================================================
	assign reg_rdata         = state.rdata;
	assign accel_out         = state.out;
	assign accel_out_valid   = state.out_valid;
	assign accel_power_en    = state.power_en;
	assign accel_bw_code     = state.bw_code;
	assign odr_strobe        = state.odr;
	assign gyro_lp_mode      = state.gyro_lp;
	assign gyro_filter_code  = state.gyro_code;
	assign gyro_avg_count    = state.gyro_count;
	assign motion_wake_level = state.wake_level;
	assign motion_wake_armed = state.wake_armed;

endmodule

// ---- hdl/avg_accumulator.sv ----
/*
 * Running sum of signed sensor samples for the averaging filter.
 * Assumes the caller clears it at the start of each averaging window.
 */
`timescale 1ns/1ps

module avg_accumulator
	import motion_filter_pkg::*;
#(
	parameter int SAMPLE_W = SAMPLE_WIDTH,
	parameter int SUM_W    = SUM_WIDTH
) (
	// Clock and reset
	input  wire logic                       sys_clk,
	input  wire logic                       rstn,
	// Control
	input  wire logic                       clear,
	input  wire logic                       add_en,
	input  wire logic signed [SAMPLE_W-1:0] sample,
	// Result
	output logic signed [SUM_W-1:0]         sum
);

	typedef struct packed {
		logic signed [SUM_W-1:0] sum;
	} acc_state_t;

	acc_state_t state;
	acc_state_t next_state;

	always_comb begin
		next_state = state;
		if (clear) begin
			// A sample arriving with the clear starts the new window.
			next_state.sum = add_en ? SUM_W'(sample) : '0;
		end else if (add_en) begin
			next_state.sum = state.sum + SUM_W'(sample);
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign sum = state.sum;

endmodule

// ---- hdl/motion_filter_pkg.sv ----
/*
 * Shared constants for the accelerometer/gyroscope filter configuration block:
 * register offsets, field positions, reset values and output-rate timing.
 * Assumes a single 25 MHz system clock.
 */
package motion_filter_pkg;

	// ==========================================================================
	// Register offsets
	// ==========================================================================
	localparam logic [7:0] ADDR_ACCEL_FILTER_CFG2    = 8'h1d;
	localparam logic [7:0] ADDR_LOW_POWER_CFG        = 8'h1e;
	localparam logic [7:0] ADDR_MOTION_WAKE_THRESHOLD = 8'h1f;

	// ==========================================================================
	// Field positions and reset values
	// ==========================================================================
	localparam int ACCEL_LP_AVG_SEL_LSB    = 4;
	localparam int ACCEL_FILTER_BYPASS_BIT = 3;
	localparam int ACCEL_LOWPASS_SEL_LSB   = 0;
	localparam int GYRO_CYCLE_BIT          = 7;
	localparam int GYRO_LP_AVG_SEL_LSB     = 4;

	localparam logic [5:0] ACCEL_CFG_RESET   = 6'h00;
	localparam logic [3:0] LP_CFG_RESET      = 4'h0;
	localparam logic [7:0] WAKE_LEVEL_RESET  = 8'h00;
	localparam logic [2:0] WAKE_EN_ALL_ONES  = 3'b111;

	// Effective accelerometer filter code when the low-pass stage is skipped.
	localparam logic [3:0] ACCEL_BW_BYPASSED = 4'h8;
	localparam logic [2:0] ACCEL_AVG_BASE_SHIFT = 3'd2;

	// ==========================================================================
	// Timing
	// ==========================================================================
	localparam int CLK_HZ            = 25_000_000;
	localparam int FILTERED_RATE_HZ  = 1_000;
	localparam int BYPASS_RATE_HZ    = 4_000;
	localparam int FILTERED_CYCLES   = CLK_HZ / FILTERED_RATE_HZ;
	localparam int BYPASS_CYCLES     = CLK_HZ / BYPASS_RATE_HZ;

	localparam int SAMPLE_WIDTH      = 16;
	localparam int SUM_WIDTH         = 21;

endpackage
